//--- rtl/phy_link_transmit_handshake.sv
// Link-side transmit handshake toward the serial bus PHY.
// Assumes the PHY keeps its own rules: grant, idle, then release.
module phy_link_transmit_handshake #(
  parameter int HOLD_LIMIT = phy_tx_pkg::MAX_HOLD
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // PHY interface pins
  input wire logic interface_clock,
  output logic link_bus_request,
  input wire logic [1:0] ctl_in,
  output logic [1:0] interface_control_lines,
  output logic ctl_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  // User side
  input wire logic tx_start,
  input wire logic [1:0] tx_speed,
  input wire logic multispeed_concat_enable,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_more,
  input wire logic [1:0] packet_speed_code,
  output logic tx_ready,
  output logic tx_busy,
  output logic [1:0] current_speed
);
  // A limit of zero would wrap the hold counter compare to 63 and force only after 64 hold cycles.
  if (HOLD_LIMIT < 1 || HOLD_LIMIT > phy_tx_pkg::MAX_HOLD) begin : g_bad_limit
    $error("HOLD_LIMIT out of range");
  end

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_WAIT = 7'h02, S_GRIDLE = 7'h04, S_HOLD = 7'h08,
    S_XMIT = 7'h10, S_END1 = 7'h20, S_END2 = 7'h40
  } state_t;

  logic rise;
  logic [2:0] ctl_s0;
  logic [2:0] ctl_s1;
  state_t state;
  state_t next_state;
  logic [5:0] hold_cnt;
  logic [5:0] next_hold_cnt;
  logic concat;
  logic next_concat;
  logic [1:0] next_current_speed;
  logic [1:0] next_ctl;
  logic next_ctl_oe;
  logic [7:0] next_data;
  logic next_data_oe;
  logic next_req;
  logic [1:0] ctl_sync;
  logic [1:0] next_ctl_sync;

  interface_clock_edge edge_det (
    .clk(clk),
    .rst(rst),
    .interface_clock(interface_clock),
    .rise(rise)
  );

  function automatic logic [7:0] speed_code(input logic [1:0] s);
    // Speed field encoding; don't-care bits go out as zero.
    unique case (s)
      phy_tx_pkg::SPEED_S200: speed_code = phy_tx_pkg::CODE_S200;
      phy_tx_pkg::SPEED_S400: speed_code = phy_tx_pkg::CODE_S400;
      default: speed_code = phy_tx_pkg::CODE_S100;
    endcase
  endfunction

  // Control lines are pin inputs: a bit counts once stages two and three
  // agree. The registered copy lags the edge pulse by one clk, so at a rise
  // it still shows what the PHY drove before that interface edge.
  always_comb begin
    next_ctl_sync = ctl_sync;
    if (ctl_s0[2] == ctl_s0[1]) begin
      next_ctl_sync[0] = ctl_s0[2];
    end
    if (ctl_s1[2] == ctl_s1[1]) begin
      next_ctl_sync[1] = ctl_s1[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_s0 <= 3'h0;
      ctl_s1 <= 3'h0;
    end else begin
      ctl_s0 <= {ctl_s0[1:0], ctl_in[0]};
      ctl_s1 <= {ctl_s1[1:0], ctl_in[1]};
    end
  end

  logic [1:0] ctl_now;
  assign ctl_now = ctl_sync;

  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_concat = concat;
    next_current_speed = current_speed;
    next_ctl = interface_control_lines;
    next_ctl_oe = ctl_oe;
    next_data = data_out;
    next_data_oe = data_oe;
    next_req = link_bus_request;
    if (rise) begin
      unique case (state)
        S_IDLE: begin
          next_ctl_oe = 1'b0;
          next_data_oe = 1'b0;
          if (tx_start) begin
            next_req = 1'b1;
            next_current_speed = tx_speed;
            next_state = S_WAIT;
          end
        end
        S_WAIT: begin
          // Grant, then the PHY's idle; we take over one cycle later.
          if (ctl_now == phy_tx_pkg::CTL_GRANT) begin
            next_req = 1'b0;
            next_state = S_GRIDLE;
          end
        end
        S_GRIDLE: begin
          // Turnaround: PHY releases after its idle, we then drive.
          next_ctl_oe = 1'b1;
          next_data_oe = 1'b1;
          next_ctl = phy_tx_pkg::CTL_HOLD;
          next_data = 8'h00;
          next_hold_cnt = 6'h0;
          next_state = S_HOLD;
        end
        S_HOLD: begin
          if (tx_valid || hold_cnt >= 6'(HOLD_LIMIT - 1)) begin
            // Hold never exceeds the limit; data is assumed ready.
            next_ctl = phy_tx_pkg::CTL_XMIT;
            next_data = tx_data;
            next_state = tx_last ? S_END1 : S_XMIT;
          end else begin
            next_hold_cnt = hold_cnt + 6'h1;
          end
        end
        S_XMIT: begin
          next_data = tx_data;
          if (tx_last) begin
            next_state = S_END1;
          end
        end
        S_END1: begin
          next_concat = tx_more;
          if (tx_more) begin
            next_ctl = phy_tx_pkg::CTL_HOLD;
            next_data = multispeed_concat_enable ?
              speed_code(packet_speed_code) : 8'h00;
            if (multispeed_concat_enable) begin
              next_current_speed = packet_speed_code;
            end
          end else begin
            next_ctl = phy_tx_pkg::CTL_IDLE;
            next_data = 8'h00;
          end
          next_state = S_END2;
        end
        S_END2: begin
          next_ctl = phy_tx_pkg::CTL_IDLE;
          next_data = 8'h00;
          next_state = concat ? S_WAIT : S_IDLE;
        end
        default: next_state = S_IDLE;
      endcase
      if (state == S_END2) begin
        next_ctl_oe = 1'b1;
      end
    end
    if (rise && state == S_IDLE && !tx_start) begin
      next_ctl = phy_tx_pkg::CTL_IDLE;
    end
    if (rise && (state == S_WAIT) && (ctl_now != phy_tx_pkg::CTL_GRANT)) begin
      next_ctl_oe = 1'b0;
      next_data_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      hold_cnt <= 6'h0;
      concat <= 1'b0;
      current_speed <= phy_tx_pkg::SPEED_S100;
      interface_control_lines <= phy_tx_pkg::CTL_IDLE;
      ctl_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      link_bus_request <= 1'b0;
      ctl_sync <= 2'h0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      concat <= next_concat;
      current_speed <= next_current_speed;
      interface_control_lines <= next_ctl;
      ctl_oe <= next_ctl_oe;
      data_out <= next_data;
      data_oe <= next_data_oe;
      link_bus_request <= next_req;
      ctl_sync <= next_ctl_sync;
    end
  end

  // In hold a byte is only taken when one is offered.
  assign tx_ready = rise && (state == S_XMIT || (state == S_HOLD && tx_valid));
  assign tx_busy = (state != S_IDLE);

  hold_bound_a: assert property (@(posedge clk) disable iff (rst)
    hold_cnt <= phy_tx_pkg::MAX_HOLD_W) else $error("hold too long");
  end_idle_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_END2) |=> interface_control_lines
      == phy_tx_pkg::CTL_IDLE) else $error("end idle missing");
  reset_release_a: assert property (@(posedge clk)
    rst |=> !ctl_oe && !data_oe) else $error("lines driven in reset");
  xmit_data_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_XMIT) |=> interface_control_lines
      == phy_tx_pkg::CTL_XMIT) else $error("transmit dropped");
  take_over_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_GRIDLE) |=> ctl_oe && interface_control_lines
      != phy_tx_pkg::CTL_IDLE) else $error("idle too long");
  speed_code_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_END1 && tx_more && multispeed_concat_enable)
      |=> data_out == speed_code($past(packet_speed_code)))
    else $error("speed code wrong");
  request_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_IDLE && tx_start) |=> link_bus_request)
    else $error("request missing");
  concat_hold_a: assert property (@(posedge clk) disable iff (rst)
    (rise && state == S_END1 && tx_more) |=> interface_control_lines
      == phy_tx_pkg::CTL_HOLD) else $error("concat hold missing");
endmodule // phy_link_transmit_handshake

//--- rtl/phy_tx_pkg.sv
// Constants for the link-side transmit handshake with the serial bus PHY.
// Assumes the PHY clocks the interface and the link samples that clock.
// Function
// - Link requests bus via request output.
// - Link codes: idle 00, hold 01, transmit 10.
// - At most one idle before hold/transmit.
// - Zero to 47 hold cycles before transmit; the link always drives at least one hold cycle.
// - Transmit with first data until last.
// - End: hold/idle, idle, then release.
// - End hold requests concatenated packet.
// - Without multispeed, one speed per ownership.
// - Multispeed: next speed on data during hold.
// - One turnaround cycle on direction change.
// - Speed codes 00/0100/0101 0000 formats.
package phy_tx_pkg;
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_HOLD = 2'h1;
  localparam logic [1:0] CTL_XMIT = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  localparam logic [1:0] SPEED_S100 = 2'h0;
  localparam logic [1:0] SPEED_S200 = 2'h1;
  localparam logic [1:0] SPEED_S400 = 2'h2;
  localparam logic [7:0] CODE_S100 = 8'h00;
  localparam logic [7:0] CODE_S200 = 8'h40;
  localparam logic [7:0] CODE_S400 = 8'h50;
  localparam int MAX_HOLD = 47;
  localparam logic [5:0] MAX_HOLD_W = 6'h2F;
endpackage

//--- rtl/interface_clock_edge.sv
// Samples the PHY interface clock and flags its rising edges.
// Assumes the interface clock is much slower than clk.
module interface_clock_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sampled clock and edge pulse
  input wire logic interface_clock,
  output logic rise
);
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic level;
  logic next_level;

  // A change counts only when the second and third stages agree.
  always_comb begin
    next_sync = {sync[1:0], interface_clock};
    next_level = level;
    if (sync[2] == sync[1]) begin
      next_level = sync[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync <= 3'h0;
      level <= 1'b0;
    end else begin
      sync <= next_sync;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level;
endmodule // interface_clock_edge

//--- testbench/phy_model.sv
// Behavioural PHY on the far side of the link control lines.
// Assumes the bench resolves the lines from the link output enable.
module phy_model (
  // Interface clock
  input wire logic interface_clock,
  // Link side
  input wire logic link_bus_request,
  input wire logic [1:0] link_ctl,
  input wire logic link_oe,
  // PHY drive
  output logic [1:0] phy_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  int st = 0;
  int gap = 0;
  logic concat = 1'b0;
  logic owned = 1'b0;
  logic [1:0] prev = 2'h0;
  initial phy_ctl = 2'h0;
  always @(posedge interface_clock) begin
    case (st)
      0: if (link_bus_request === 1'b1 || concat) begin
        st <= 1;
        gap <= 3;
      end
      1: if (gap == 0) begin
        phy_ctl <= 2'h3;
        concat <= 1'b0;
        st <= 2;
      end else begin
        gap <= gap - 1;
      end
      2: begin
        phy_ctl <= 2'h0;
        prev <= 2'h0;
        owned <= 1'b0;
        st <= 3;
      end
      default: begin
        // Released lines wander so a stale level is never trusted.
        phy_ctl <= (phy_ctl == 2'h1) ? 2'h2 : 2'h1;
        if (link_oe === 1'b1) begin
          owned <= 1'b1;
          prev <= link_ctl;
          if (prev == 2'h2 && link_ctl == 2'h1) concat <= 1'b1;
        end else if (owned) begin
          phy_ctl <= 2'h0;
          st <= 0;
        end
      end
    endcase
  end
endmodule // phy_model

//--- testbench/tb_phy_link_transmit_handshake.sv
// Self-checking bench for the link transmit handshake.
// Assumes the PHY model answers on the control lines.
module tb_phy_link_transmit_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic interface_clock = 1'b0;
  logic tx_start = 1'b0, multispeed_concat_enable = 1'b0, tx_valid = 1'b0;
  logic tx_last = 1'b0, tx_more = 1'b0, link_bus_request, ctl_oe, data_oe;
  logic tx_ready, tx_busy;
  logic [1:0] tx_speed = 2'h0, packet_speed_code = 2'h0, ctl_in, phy_ctl;
  logic [1:0] interface_control_lines, current_speed;
  logic [7:0] tx_data = 8'h00, data_out;
  logic [31:0] seed = 32'h5860;
  int error_cnt = 0;
  int tests_run = 0;
  logic [1:0] cq[$];
  logic [7:0] dq[$], pkt[$];
  always #50 clk = ~clk;
  initial #137 forever #400 interface_clock = ~interface_clock;
  assign ctl_in = ctl_oe ? interface_control_lines : phy_ctl;
  phy_link_transmit_handshake i_phy_link_transmit_handshake (.clk, .rst,
    .interface_clock, .link_bus_request, .ctl_in, .interface_control_lines,
    .ctl_oe, .data_out, .data_oe, .tx_start, .tx_speed,
    .multispeed_concat_enable, .tx_valid, .tx_data, .tx_last, .tx_more,
    .packet_speed_code, .tx_ready, .tx_busy, .current_speed);
  phy_model i_phy_model (.interface_clock, .link_bus_request,
    .link_ctl(interface_control_lines), .link_oe(ctl_oe), .phy_ctl);
  always @(posedge interface_clock) begin
    if (ctl_oe === 1'b1) begin
      cq.push_back(interface_control_lines);
      dq.push_back(data_out);
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] speed_byte(input logic [1:0] s);
    return (s == 2'h0) ? 8'h00 : (s == 2'h1) ? 8'h40 : 8'h50;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(input bit ok);
    if (!ok) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic send(input int n, hold, input logic more, first,
                      input logic [1:0] nspd);
    int k;
    int i;
    @(posedge clk);
    cq.delete();
    dq.delete();
    pkt.delete();
    tx_more <= more;
    packet_speed_code <= nspd;
    tx_start <= first;
    for (k = 0; k < 3000 && ctl_oe !== 1'b1; k++) @(posedge clk);
    guard(ctl_oe === 1'b1);
    tx_start <= 1'b0;
    chk("req_dropped_oe", 8'({link_bus_request, data_oe}), 8'h01);
    chk("busy_owning", 8'(tx_busy), 8'h01);
    repeat (hold) @(posedge interface_clock);
    @(posedge clk);
    for (i = 0; i < n; i++) begin
      pkt.push_back(8'(rnd()));
      tx_valid <= 1'b1;
      tx_data <= pkt[i];
      tx_last <= 1'(i == n - 1);
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (k < 200 && tx_ready !== 1'b1);
      guard(tx_ready === 1'b1);
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    for (k = 0; k < 300 && ctl_oe !== 1'b0; k++) @(negedge clk);
    guard(ctl_oe === 1'b0);
    chk("released", 8'({tx_busy, data_oe}), more ? 8'h02 : 8'h00);
    i = (cq.size() > 0 && cq[0] === 2'h0) ? 1 : 0;
    k = 0;
    while (i < cq.size() && cq[i] === 2'h1) begin
      k++;
      i++;
    end
    chk("holds_within_limit", 8'(k <= 47), 8'h01);
    for (k = 0; k < n; k++) begin
      chk("ctl_transmit", 8'(cq[i + k]), 8'h02);
      chk("packet_data", dq[i + k], pkt[k]);
    end
    i = i + n;
    chk("end_code", 8'(cq[i]), more ? 8'h01 : 8'h00);
    if (more && multispeed_concat_enable) begin
      chk("next_speed", dq[i], speed_byte(nspd));
    end
    chk("end_idle", 8'(cq[i + 1]), 8'h00);
    chk("owner_cycles", 8'(cq.size()), 8'(i + 2));
  endtask
  initial begin
    logic [31:0] r;
    logic [1:0] s0;
    logic [1:0] nspd;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe_after_reset", {6'h00, ctl_oe, data_oe}, 8'h00);
    chk("request_after_reset", 8'(link_bus_request), 8'h00);
    for (int t = 0; t < 6; t++) begin
      r = rnd();
      s0 = 2'(t % 3);
      nspd = 2'((t + 1) % 3);
      @(posedge clk);
      multispeed_concat_enable <= r[0];
      tx_speed <= s0;
      // A one-byte packet with no hold is the tightest corner.
      send((t == 0) ? 1 : 1 + r[3:2], (t == 0) ? 0 : r[5:4], 1'b1, 1'b1,
           nspd);
      send(1 + r[7:6], r[9:8], 1'b0, 1'b0, nspd);
      chk("speed_kept", 8'(current_speed),
          8'(multispeed_concat_enable ? nspd : s0));
      $display("test %0d done, mismatches %0d", t, error_cnt);
    end
    report_and_stop();
  end
endmodule // tb_phy_link_transmit_handshake
